// ### hdl/sasd_pkg.sv
// Constants and types shared by the packed add/subtract datapath
package sasd_pkg;
	// ****************************************************************
	// Operation select
	// ****************************************************************
	typedef enum logic [4:0] {
		OP_PAIR_Q15_ADD = 5'h00,
		OP_PAIR_Q15_ADD_SAT = 5'h01,
		OP_WORD_Q31_ADD_SAT = 5'h02,
		OP_QUAD_UBYTE_ADD = 5'h03,
		OP_QUAD_UBYTE_ADD_SAT = 5'h04,
		OP_QUAD_UBYTE_ADD_HALVE = 5'h05,
		OP_QUAD_UBYTE_ADD_HALVE_ROUND = 5'h06,
		OP_PAIR_UHALF_ADD = 5'h07,
		OP_PAIR_UHALF_ADD_SAT = 5'h08,
		OP_PAIR_SHALF_ADD_HALVE = 5'h09,
		OP_PAIR_SHALF_ADD_HALVE_ROUND = 5'h0A,
		OP_SWORD_ADD_HALVE = 5'h0B,
		OP_SWORD_ADD_HALVE_ROUND = 5'h0C,
		OP_PAIR_Q15_SUB = 5'h0D,
		OP_PAIR_Q15_SUB_SAT = 5'h0E,
		OP_WORD_Q31_SUB_SAT = 5'h0F,
		OP_QUAD_UBYTE_SUB = 5'h10,
		OP_QUAD_UBYTE_SUB_SAT = 5'h11,
		OP_QUAD_UBYTE_SUB_HALVE = 5'h12,
		OP_QUAD_UBYTE_SUB_HALVE_ROUND = 5'h13,
		OP_PAIR_UHALF_SUB = 5'h14,
		OP_PAIR_UHALF_SUB_SAT = 5'h15
	} sasd_op_t;

	// ****************************************************************
	// Lane formats handled by the lane unit
	// ****************************************************************
	typedef enum logic [2:0] {
		FMT_Q15 = 3'h0,
		FMT_Q31 = 3'h1,
		FMT_UBYTE = 3'h2,
		FMT_UHALF = 3'h3,
		FMT_SHALF = 3'h4,
		FMT_SWORD = 3'h5
	} sasd_fmt_t;

	// ****************************************************************
	// Control register flag field and exception codes
	// ****************************************************************
	localparam int OUFLAG_LSB = 16;
	localparam int OUFLAG_MSB = 23;
	localparam int OUFLAG_ADDSUB_BIT = 20;
	localparam logic [7:0] OUFLAG_RESET = 8'h00;
	localparam logic [4:0] EXC_CODE_NONE = 5'h00;
	localparam logic [4:0] EXC_CODE_RESERVED = 5'h0A;
	localparam logic [4:0] EXC_CODE_EXT_DISABLED = 5'h1A;
	localparam logic [31:0] RESULT_RESET = 32'h0000_0000;
endpackage : sasd_pkg

// ### hdl/sasd_lane.sv
// One 32-bit packed add/subtract lane group with saturation and halving
`timescale 1ns/1ps
module sasd_lane
	import sasd_pkg::*;
(
	input wire logic [31:0] a_i, // First source low word
	input wire logic [31:0] b_i, // Second source low word
	input wire sasd_fmt_t fmt_i, // Lane format
	input wire logic sub_i, // Subtract when high
	input wire logic sat_i, // Clamp instead of wrap
	input wire logic halve_i, // Shift the wide result right
	input wire logic round_i, // Add one before halving
	output logic [31:0] res_o, // Packed result
	output logic ovf_o // Any lane overflowed or underflowed
);
	logic [3:0] byte_ovf;
	logic [1:0] half_ovf;
	logic [31:0] byte_res;
	logic [31:0] half_res;
	logic [31:0] word_res;
	logic word_ovf;

	// ****************************************************************
	// Byte lanes: unsigned, nine bits wide so no carry is lost
	// ****************************************************************
	for (genvar i = 0; i < 4; i++) begin : g_byte
		logic [8:0] wide;
		logic [8:0] rnd;
		always_comb begin
			wide = sub_i ? ({1'b0, a_i[8*i+:8]} - {1'b0, b_i[8*i+:8]})
				: ({1'b0, a_i[8*i+:8]} + {1'b0, b_i[8*i+:8]});
			rnd = wide + {8'h00, round_i};
			byte_ovf[i] = wide[8] && !halve_i;
			if (halve_i) begin
				byte_res[8*i+:8] = rnd[8:1];
			end else if (sat_i && wide[8]) begin
				byte_res[8*i+:8] = sub_i ? 8'h00 : 8'hFF;
			end else begin
				byte_res[8*i+:8] = wide[7:0];
			end
		end
	end

	// ****************************************************************
	// Halfword lanes: Q15, unsigned or signed, seventeen bits wide
	// ****************************************************************
	for (genvar i = 0; i < 2; i++) begin : g_half
		logic [16:0] ea;
		logic [16:0] eb;
		logic [16:0] wide;
		logic [16:0] rnd;
		logic uns;
		logic ov;
		always_comb begin
			uns = (fmt_i == FMT_UHALF);
			ea = {uns ? 1'b0 : a_i[16*i+15], a_i[16*i+:16]};
			eb = {uns ? 1'b0 : b_i[16*i+15], b_i[16*i+:16]};
			wide = sub_i ? ea - eb : ea + eb;
			rnd = wide + {16'h0000, round_i};
			ov = uns ? wide[16] : (wide[16] != wide[15]);
			half_ovf[i] = ov && !halve_i;
			if (halve_i) begin
				half_res[16*i+:16] = rnd[16:1];
			end else if (sat_i && ov && uns) begin
				half_res[16*i+:16] = sub_i ? 16'h0000 : 16'hFFFF;
			end else if (sat_i && ov) begin
				half_res[16*i+:16] = wide[16] ? 16'h8000 : 16'h7FFF;
			end else begin
				half_res[16*i+:16] = wide[15:0];
			end
		end
	end

	// ****************************************************************
	// Word lane: Q31 saturating or signed halving
	// ****************************************************************
	logic [32:0] wwide;
	logic [32:0] wrnd;
	always_comb begin
		wwide = sub_i ? {a_i[31], a_i} - {b_i[31], b_i}
			: {a_i[31], a_i} + {b_i[31], b_i};
		wrnd = wwide + {32'h0000_0000, round_i};
		word_ovf = (wwide[32] != wwide[31]) && !halve_i;
		if (halve_i) begin
			word_res = wrnd[32:1];
		end else if (word_ovf) begin
			word_res = wwide[32] ? 32'h8000_0000 : 32'h7FFF_FFFF;
		end else begin
			word_res = wwide[31:0];
		end
	end

	always_comb begin
		case (fmt_i)
			FMT_UBYTE: begin
				res_o = byte_res;
				ovf_o = |byte_ovf;
			end
			FMT_Q31, FMT_SWORD: begin
				res_o = word_res;
				ovf_o = word_ovf;
			end
			default: begin
				res_o = half_res;
				ovf_o = |half_ovf;
			end
		endcase
	end
endmodule // sasd_lane

// ### hdl/sasd_datapath.sv
// Packed add/subtract execution datapath with flag update and trap checks
// Contract
// - Pair Q15 add lane by lane; saturating form clamps to Q15 range.
// - Q31 word add always saturates on overflow.
// - Quad unsigned byte add; saturating clamps to 0xFF, plain wraps.
// - Halving byte add shifts sums right one; rounding form adds one first.
// - Pair unsigned halfword add/sub; saturating clamps, plain wraps.
// - Halving signed halfword add keeps sign; rounding form adds one.
// - Halving signed word add keeps carry; rounding form adds one.
// - Pair Q15 subtract lane by lane; saturating form clamps.
// - Q31 word subtract always saturates on overflow.
// - Quad byte subtract; saturating clamps negatives to zero, plain wraps.
// - Halving byte subtract; rounding adds one at top discarded bit.
// - Result is 32 bits, sign-extended into the upper 32 bits.
// - Only destination register and overflow flag field are written.
// - Revision-two operations raise reserved-instruction when rev2 absent.
// - Extension disabled traps with state-disabled cause 26.
// - Never raise an arithmetic overflow exception.
`timescale 1ns/1ps
module sasd_datapath
	import sasd_pkg::*;
(
	input wire logic clk_sys_i, // Core clock, 25 MHz
	input wire logic rst_n_i, // Asynchronous reset, active low
	input wire logic issue_i, // Operation issued this cycle
	input wire sasd_op_t op_i, // Operation select
	input wire logic [63:0] src_a_i, // First source general register
	input wire logic [63:0] src_b_i, // Second source general register
	input wire logic extension_state_enable_i, // Extension enable from status
	input wire logic extension_present_bit_i, // Extension implemented
	input wire logic extension_rev2_present_bit_i, // Revision two implemented
	input wire logic ctrl_wr_i, // Explicit write of the flag field
	input wire logic [7:0] ctrl_flags_i, // Value for that write
	output logic wr_en_o, // Destination write strobe
	output logic [63:0] wr_data_o, // Destination value
	output logic exc_o, // Exception instead of write
	output logic [4:0] exc_code_o, // Exception cause code
	output logic [7:0] extension_control_flags_o // Control bits 23..16
);
	sasd_fmt_t fmt;
	logic sub;
	logic sat;
	logic halve;
	logic round;
	logic rev2;
	logic [31:0] lane_res;
	logic lane_ovf;
	logic wr_en_d, wr_en_q;
	logic [63:0] wr_data_d, wr_data_q;
	logic exc_d, exc_q;
	logic [4:0] exc_code_d, exc_code_q;
	logic [7:0] flags_d, flags_q;

	// ****************************************************************
	// Decode
	// ****************************************************************
	always_comb begin
		fmt = FMT_Q15;
		sub = 1'b0;
		sat = 1'b0;
		halve = 1'b0;
		round = 1'b0;
		rev2 = 1'b0;
		case (op_i)
			OP_PAIR_Q15_ADD: fmt = FMT_Q15;
			OP_PAIR_Q15_ADD_SAT: begin
				sat = 1'b1;
			end
			OP_WORD_Q31_ADD_SAT: begin
				fmt = FMT_Q31;
				sat = 1'b1;
			end
			OP_QUAD_UBYTE_ADD: fmt = FMT_UBYTE;
			OP_QUAD_UBYTE_ADD_SAT: begin
				fmt = FMT_UBYTE;
				sat = 1'b1;
			end
			OP_QUAD_UBYTE_ADD_HALVE, OP_QUAD_UBYTE_ADD_HALVE_ROUND: begin
				fmt = FMT_UBYTE;
				halve = 1'b1;
				round = (op_i == OP_QUAD_UBYTE_ADD_HALVE_ROUND);
				rev2 = 1'b1;
			end
			OP_PAIR_UHALF_ADD, OP_PAIR_UHALF_ADD_SAT: begin
				fmt = FMT_UHALF;
				sat = (op_i == OP_PAIR_UHALF_ADD_SAT);
				rev2 = 1'b1;
			end
			OP_PAIR_SHALF_ADD_HALVE, OP_PAIR_SHALF_ADD_HALVE_ROUND: begin
				fmt = FMT_SHALF;
				halve = 1'b1;
				round = (op_i == OP_PAIR_SHALF_ADD_HALVE_ROUND);
				rev2 = 1'b1;
			end
			OP_SWORD_ADD_HALVE, OP_SWORD_ADD_HALVE_ROUND: begin
				fmt = FMT_SWORD;
				halve = 1'b1;
				round = (op_i == OP_SWORD_ADD_HALVE_ROUND);
				rev2 = 1'b1;
			end
			OP_PAIR_Q15_SUB: sub = 1'b1;
			OP_PAIR_Q15_SUB_SAT: begin
				sub = 1'b1;
				sat = 1'b1;
			end
			OP_WORD_Q31_SUB_SAT: begin
				fmt = FMT_Q31;
				sub = 1'b1;
				sat = 1'b1;
			end
			OP_QUAD_UBYTE_SUB, OP_QUAD_UBYTE_SUB_SAT: begin
				fmt = FMT_UBYTE;
				sub = 1'b1;
				sat = (op_i == OP_QUAD_UBYTE_SUB_SAT);
			end
			OP_QUAD_UBYTE_SUB_HALVE, OP_QUAD_UBYTE_SUB_HALVE_ROUND: begin
				fmt = FMT_UBYTE;
				sub = 1'b1;
				halve = 1'b1;
				round = (op_i == OP_QUAD_UBYTE_SUB_HALVE_ROUND);
				rev2 = 1'b1;
			end
			OP_PAIR_UHALF_SUB, OP_PAIR_UHALF_SUB_SAT: begin
				fmt = FMT_UHALF;
				sub = 1'b1;
				sat = (op_i == OP_PAIR_UHALF_SUB_SAT);
				rev2 = 1'b1;
			end
			default: fmt = FMT_Q15;
		endcase
	end

	sasd_lane u_lane (
		.a_i(src_a_i[31:0]),
		.b_i(src_b_i[31:0]),
		.fmt_i(fmt),
		.sub_i(sub),
		.sat_i(sat),
		.halve_i(halve),
		.round_i(round),
		.res_o(lane_res),
		.ovf_o(lane_ovf)
	);

	// ****************************************************************
	// Result, trap and flag next state
	// ****************************************************************
	always_comb begin
		wr_en_d = 1'b0;
		wr_data_d = wr_data_q;
		exc_d = 1'b0;
		exc_code_d = EXC_CODE_NONE;
		flags_d = ctrl_wr_i ? ctrl_flags_i : flags_q;
		if (issue_i) begin
			// Presence is checked before enable, so a missing unit never reports 26
			if (!extension_present_bit_i || (rev2 && !extension_rev2_present_bit_i)) begin
				exc_d = 1'b1;
				exc_code_d = EXC_CODE_RESERVED;
			end else if (!extension_state_enable_i) begin
				exc_d = 1'b1;
				exc_code_d = EXC_CODE_EXT_DISABLED;
			end else begin
				// Overflow never traps; it only sets the sticky flag
				wr_en_d = 1'b1;
				wr_data_d = {{32{lane_res[31]}}, lane_res};
				if (lane_ovf) begin
					flags_d[OUFLAG_ADDSUB_BIT - OUFLAG_LSB] = 1'b1;
				end
			end
		end
	end

	always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			wr_en_q <= 1'b0;
			wr_data_q <= {RESULT_RESET, RESULT_RESET};
			exc_q <= 1'b0;
			exc_code_q <= EXC_CODE_NONE;
			flags_q <= OUFLAG_RESET;
		end else begin
			wr_en_q <= wr_en_d;
			wr_data_q <= wr_data_d;
			exc_q <= exc_d;
			exc_code_q <= exc_code_d;
			flags_q <= flags_d;
		end
	end

	assign wr_en_o = wr_en_q;
	assign wr_data_o = wr_data_q;
	assign exc_o = exc_q;
	assign exc_code_o = exc_code_q;
	assign extension_control_flags_o = flags_q;

	// ****************************************************************
	// Assertions
	// ****************************************************************
	sequence s_ok_issue;
		issue_i && extension_present_bit_i && extension_state_enable_i
			&& (!rev2 || extension_rev2_present_bit_i);
	endsequence

	a_sign_extend: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
		wr_en_o |-> wr_data_o[63:32] == {32{wr_data_o[31]}})
		else $error("upper half not sign extension");
	a_write_on_issue: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
		s_ok_issue |=> wr_en_o && !exc_o)
		else $error("valid issue did not write");
	a_disabled_trap: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
		issue_i && extension_present_bit_i && !extension_state_enable_i
			&& (!rev2 || extension_rev2_present_bit_i)
		|=> exc_o && exc_code_o == EXC_CODE_EXT_DISABLED && !wr_en_o)
		else $error("disabled trap wrong");
	a_rev2_reserved: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
		issue_i && rev2 && !extension_rev2_present_bit_i
		|=> exc_o && exc_code_o == EXC_CODE_RESERVED)
		else $error("rev2 op not reserved");
	a_no_ovf_trap: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
		s_ok_issue ##0 lane_ovf |=> !exc_o)
		else $error("overflow trapped");
	// The write that changed the flags was sampled one edge back, not at this edge
	a_flag_sticky: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
		!$past(ctrl_wr_i) && $past(extension_control_flags_o[4])
		|-> extension_control_flags_o[4] || !$past(rst_n_i))
		else $error("flag cleared by operation");
	a_flag_set: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
		s_ok_issue ##0 lane_ovf |=> extension_control_flags_o[4])
		else $error("overflow flag not set");
	a_q31_clamp: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
		s_ok_issue ##0 (op_i == OP_WORD_Q31_ADD_SAT) ##0 lane_ovf
		|=> wr_data_o[31:0] == 32'h7FFF_FFFF || wr_data_o[31:0] == 32'h8000_0000)
		else $error("q31 add not clamped");
	a_ubyte_sat: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
		s_ok_issue ##0 (op_i == OP_QUAD_UBYTE_ADD_SAT) ##0 (src_a_i[7:0] == 8'hFF)
		|=> wr_data_o[7:0] == 8'hFF)
		else $error("byte add not clamped");
endmodule // sasd_datapath

// ### verification/sasd_core_model.sv
// Core pipeline model that issues packed operations and collects the answers
`timescale 1ns/1ps
module sasd_core_model
	import sasd_pkg::*;
(
	input wire logic clk_sys_i, // Core clock
	output sasd_op_t op_o, // Operation select
	output logic issue_o, // Issue strobe
	output logic [63:0] src_a_o, // First source
	output logic [63:0] src_b_o, // Second source
	input wire logic wr_en_i, // Destination write strobe
	input wire logic [63:0] wr_data_i, // Destination value
	input wire logic exc_i, // Exception strobe
	input wire logic [4:0] exc_code_i // Exception cause
);
	logic got_wr;
	logic got_exc;
	logic [63:0] got_data;
	logic [4:0] got_code;
	initial begin
		issue_o = 1'b0;
		op_o = OP_PAIR_Q15_ADD;
		src_a_o = 64'h0;
		src_b_o = 64'h0;
	end
	// Called at a falling edge; keep leaves the strobe up for a back-to-back issue.
	// Upper source halves carry garbage since only the low word may matter.
	task automatic issue(input sasd_op_t op, input logic [31:0] a, input logic [31:0] b,
		input bit keep);
		issue_o = 1'b1;
		op_o = op;
		src_a_o = {~a, a};
		src_b_o = {~b, b};
		@(negedge clk_sys_i);
		got_wr = wr_en_i;
		got_exc = exc_i;
		got_data = wr_data_i;
		got_code = exc_code_i;
		if (!keep) begin
			// Released lines show the inverse so stale sampling cannot pass
			issue_o = 1'b0;
			op_o = sasd_op_t'(~op_o);
			src_a_o = ~src_a_o;
			src_b_o = ~src_b_o;
		end
	endtask
endmodule // sasd_core_model

// ### verification/sasd_datapath_bench.sv
// Self-checking bench for the packed add/subtract datapath
`timescale 1ns/1ps
module sasd_datapath_bench
	import sasd_pkg::*;
;
	typedef struct packed {
		sasd_op_t op;
		logic [31:0] a;
		logic [31:0] b;
		logic [31:0] res;
		logic ovf;
	} sasd_row_t;
	localparam sasd_row_t ROWS [22] = '{
		'{OP_PAIR_Q15_ADD, 32'h7FFF_0001, 32'h0001_0001, 32'h8000_0002, 1'b1},
		'{OP_PAIR_Q15_ADD_SAT, 32'h7FFF_0001, 32'h0001_0001, 32'h7FFF_0002, 1'b1},
		'{OP_WORD_Q31_ADD_SAT, 32'h8000_0000, 32'hFFFF_FFFF, 32'h8000_0000, 1'b1},
		'{OP_QUAD_UBYTE_ADD, 32'hFF80_0102, 32'h0180_0304, 32'h0000_0406, 1'b1},
		'{OP_QUAD_UBYTE_ADD_SAT, 32'hFF80_0102, 32'h0180_0304, 32'hFFFF_0406, 1'b1},
		'{OP_QUAD_UBYTE_ADD_HALVE, 32'hFF01_0203, 32'hFF02_0201, 32'hFF01_0202, 1'b0},
		'{OP_QUAD_UBYTE_ADD_HALVE_ROUND, 32'hFF01_0203, 32'hFF02_0201, 32'hFF02_0202, 1'b0},
		'{OP_PAIR_UHALF_ADD, 32'hFFFF_1234, 32'h0002_0001, 32'h0001_1235, 1'b1},
		'{OP_PAIR_UHALF_ADD_SAT, 32'hFFFF_1234, 32'h0002_0001, 32'hFFFF_1235, 1'b1},
		'{OP_PAIR_SHALF_ADD_HALVE, 32'h7FFF_8000, 32'h7FFF_8001, 32'h7FFF_8000, 1'b0},
		'{OP_PAIR_SHALF_ADD_HALVE_ROUND, 32'h7FFF_8000, 32'h7FFF_8001, 32'h7FFF_8001, 1'b0},
		'{OP_SWORD_ADD_HALVE, 32'h7FFF_FFFF, 32'h7FFF_FFFF, 32'h7FFF_FFFF, 1'b0},
		'{OP_SWORD_ADD_HALVE_ROUND, 32'h7FFF_FFFF, 32'h0000_0000, 32'h4000_0000, 1'b0},
		'{OP_PAIR_Q15_SUB, 32'h8000_0005, 32'h0001_0007, 32'h7FFF_FFFE, 1'b1},
		'{OP_PAIR_Q15_SUB_SAT, 32'h8000_0005, 32'h0001_0007, 32'h8000_FFFE, 1'b1},
		'{OP_WORD_Q31_SUB_SAT, 32'h7FFF_FFFF, 32'hFFFF_FFFF, 32'h7FFF_FFFF, 1'b1},
		'{OP_QUAD_UBYTE_SUB, 32'h0010_FF05, 32'h0108_0006, 32'hFF08_FFFF, 1'b1},
		'{OP_QUAD_UBYTE_SUB_SAT, 32'h0010_FF05, 32'h0108_0006, 32'h0008_FF00, 1'b1},
		'{OP_QUAD_UBYTE_SUB_HALVE, 32'h0010_FF05, 32'h0108_0004, 32'hFF04_7F00, 1'b0},
		'{OP_QUAD_UBYTE_SUB_HALVE_ROUND, 32'h0010_FF05, 32'h0108_0004, 32'h0004_8001, 1'b0},
		'{OP_PAIR_UHALF_SUB, 32'h0000_0005, 32'h0001_0003, 32'hFFFF_0002, 1'b1},
		'{OP_PAIR_UHALF_SUB_SAT, 32'h0000_0005, 32'h0001_0003, 32'h0000_0002, 1'b1}
	};
	logic clk_sys = 1'b0;
	logic rst_n = 1'b0;
	logic ext_en = 1'b1;
	logic ext_p = 1'b1;
	logic ext_p2 = 1'b1;
	logic ctrl_wr = 1'b0;
	logic [7:0] ctrl_flags = 8'h00;
	logic issue;
	sasd_op_t op;
	logic [63:0] src_a;
	logic [63:0] src_b;
	logic wr_en;
	logic [63:0] wr_data;
	logic exc;
	logic [4:0] exc_code;
	logic [7:0] flags;
	int fail_count = 0;
	int compares = 0;
	always #20 clk_sys = ~clk_sys;
	sasd_datapath dut (.clk_sys_i(clk_sys), .rst_n_i(rst_n), .issue_i(issue), .op_i(op),
		.src_a_i(src_a), .src_b_i(src_b), .extension_state_enable_i(ext_en),
		.extension_present_bit_i(ext_p), .extension_rev2_present_bit_i(ext_p2),
		.ctrl_wr_i(ctrl_wr), .ctrl_flags_i(ctrl_flags), .wr_en_o(wr_en), .wr_data_o(wr_data),
		.exc_o(exc), .exc_code_o(exc_code), .extension_control_flags_o(flags));
	sasd_core_model core (.clk_sys_i(clk_sys), .op_o(op), .issue_o(issue), .src_a_o(src_a),
		.src_b_o(src_b), .wr_en_i(wr_en), .wr_data_i(wr_data), .exc_i(exc),
		.exc_code_i(exc_code));
	task automatic chk(input logic [63:0] got, input logic [63:0] exp);
		compares++;
		if (got !== exp) begin
			fail_count++;
			$display("Error at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	// Flag write lasts one edge; called at a falling edge
	task automatic ctrl_put(input logic [7:0] f);
		ctrl_wr = 1'b1;
		ctrl_flags = f;
		@(negedge clk_sys);
		ctrl_wr = 1'b0;
	endtask
	task automatic tally_and_finish();
		$display("Comparisons %0d, mismatches %0d", compares, fail_count);
		if (fail_count == 0 && compares > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask
	// ****************************************************************
	// Watchdog: every wait below is fixed, so this only trips on a stall
	// ****************************************************************
	initial begin
		repeat (3000) @(posedge clk_sys);
		fail_count++;
		tally_and_finish();
	end
	logic [3:0] ex_cfg [5] = '{4'b1101, 4'b1100, 4'b0011, 4'b0100, 4'b0101};
	logic [4:0] ex_code [5] = '{5'h0A, 5'h0A, 5'h0A, 5'h1A, 5'h00};
	initial begin
		repeat (5) @(negedge clk_sys);
		rst_n = 1'b1;
		for (int i = 0; i < 22; i++) begin
			ctrl_put(8'h00);
			core.issue(ROWS[i].op, ROWS[i].a, ROWS[i].b, 1'b0);
			chk({62'h0, core.got_exc, core.got_wr}, 64'h1);
			chk(core.got_data, {{32{ROWS[i].res[31]}}, ROWS[i].res});
			chk({56'h0, flags}, {59'h0, ROWS[i].ovf, 4'h0});
		end
		$display("Test table done");
		// Refused cases: config {rev2 op, present, rev2, enable}; last one executes
		for (int i = 0; i < 5; i++) begin
			// Clears the flags left by the table and spaces the issues by one edge
			ctrl_put(8'h00);
			{ext_p, ext_p2, ext_en} = ex_cfg[i][2:0];
			core.issue(ex_cfg[i][3] ? OP_QUAD_UBYTE_ADD_HALVE : OP_PAIR_Q15_ADD_SAT,
				32'h7FFF_0000, 32'h0001_0000, 1'b0);
			chk({62'h0, core.got_exc, core.got_wr}, (i == 4) ? 64'h1 : 64'h2);
			chk({59'h0, core.got_code}, {59'h0, ex_code[i]});
			chk(core.got_data, (i == 4) ? 64'h7FFF_0000 : 64'h2);
			chk({56'h0, flags}, (i == 4) ? 64'h10 : 64'h0);
		end
		$display("Test exceptions done");
		{ext_p, ext_p2, ext_en} = 3'b111;
		ctrl_put(8'h00);
		core.issue(OP_WORD_Q31_ADD_SAT, 32'h7FFF_FFFF, 32'h0000_0001, 1'b1);
		chk(core.got_data, 64'h7FFF_FFFF);
		core.issue(OP_PAIR_UHALF_SUB, 32'h0005_0005, 32'h0001_0002, 1'b0);
		chk({63'h0, core.got_wr}, 64'h1);
		chk(core.got_data, 64'h0004_0003);
		chk({56'h0, flags}, 64'h10);
		$display("Test back to back done");
		ctrl_put(8'hA1);
		chk({56'h0, flags}, 64'hA1);
		@(negedge clk_sys);
		ctrl_wr = 1'b1;
		ctrl_flags = 8'h00;
		fork
			core.issue(OP_QUAD_UBYTE_ADD_SAT, 32'h0000_00FF, 32'h0000_0001, 1'b0);
			begin
				@(negedge clk_sys);
				ctrl_wr = 1'b0;
			end
		join
		chk(core.got_data, 64'hFF);
		chk({56'h0, flags}, 64'h10);
		$display("Test flag write done");
		rst_n = 1'b0;
		#1;
		chk({wr_data, wr_en, exc, exc_code, flags}, 79'h0);
		@(negedge clk_sys);
		rst_n = 1'b1;
		// Issue at the first edge after release; no lane overflows, so flags stay cleared
		core.issue(OP_QUAD_UBYTE_SUB_SAT, 32'h0504_0302, 32'h0101_0101, 1'b0);
		chk({62'h0, core.got_exc, core.got_wr}, 64'h1);
		chk(core.got_data, 64'h0403_0201);
		chk({56'h0, flags}, 64'h0);
		$display("Test mid-run reset done");
		tally_and_finish();
	end
endmodule // sasd_datapath_bench
